//--- inc/cpu_regs_cfg.svh
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH

// register byte offsets
`define OFS_GP_WORD_0 8'h00
`define OFS_GP_WORD_1 8'h04
`define OFS_GP_WORD_2 8'h08
`define OFS_GP_WORD_3 8'h0c
`define OFS_PTR_REG_0 8'h10
`define OFS_PTR_REG_1 8'h14
`define OFS_FRAME_BASE 8'h18
`define OFS_VECTOR_BASE 8'h1c
`define OFS_PROG_COUNTER 8'h20
`define OFS_USER_SP 8'h24
`define OFS_IRQ_SP 8'h28
`define OFS_STATIC_BASE 8'h2c
`define OFS_FLAG_WORD 8'h30
`define OFS_ACTIVE_SP 8'h34
`define OFS_GP_LONG_LOW 8'h38
`define OFS_GP_LONG_HIGH 8'h3c
`define OFS_PTR_LONG 8'h40

// banked register indices
`define IDX_GP_WORD_0 3'h0
`define IDX_GP_WORD_1 3'h1
`define IDX_GP_WORD_2 3'h2
`define IDX_GP_WORD_3 3'h3
`define IDX_PTR_REG_0 3'h4
`define IDX_PTR_REG_1 3'h5
`define IDX_FRAME_BASE 3'h6
`define IDX_NONE 3'h7

// flag word field positions
`define FLG_BORROW_OUT 0
`define FLG_TRACE 1
`define FLG_NULL_RESULT 2
`define FLG_NEGATIVE 3
`define FLG_GROUP_SEL 4
`define FLG_ARITH_WRAP 5
`define FLG_MASK_GATE 6
`define FLG_STACK_CHOICE 7
`define FLG_PRIO_LO 8
`define FLG_PRIO_HI 10

// reset values
`define RST_WORD16 16'h0000
`define RST_WORD20 20'h00000
`define RST_FLAG_WORD 11'h000

// software trap numbers below this switch to the interrupt stack
`define SOFT_TRAP_SWITCH_LIMIT 6'h20

`endif

//--- inc/cpu_regs_pkg.sv
package cpu_regs_pkg;

  typedef enum logic [1:0]
  {
    bus_idle = 2'b01,
    bus_ack = 2'b10
  } bus_state_e;

  typedef enum logic [1:0]
  {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } alu_size_e;

  typedef logic [15:0] word16_t;
  typedef logic [19:0] word20_t;
  typedef logic [10:0] flag_t;

endpackage

//--- hdl/cpu_register_set_and_flags.sv
// Notes on behaviour
// - thirteen registers; gp words, pointers and frame base form one bank, two copies.
// - group select flag 0 picks bank 0, 1 picks bank 1.
// - four 16-bit general words; words 0 and 1 also split into byte halves.
// - word 2 with word 0, and word 3 with word 1, form 32-bit pairs.
// - two 16-bit pointer registers, also paired into one 32-bit value.
// - 16-bit frame base pointer gives the base for frame-relative addressing.
// - 20-bit vector table base holds the interrupt table start address.
// - 20-bit program counter holds the next instruction address.
// - stack choice 0 selects interrupt stack, 1 selects user stack.
// - accepted hardware interrupt or soft trap 0..31 clears stack choice.
// - 16-bit static base pointer gives the static-relative base.
// - flag word is 11 bits of processor status.
// - borrow out flag keeps carry, borrow or shifted-out bit of last op.
// - null result flag is 1 for zero result, else 0.
// - negative flag is 1 for negative result, else 0.
// - arithmetic wrap flag is 1 on signed overflow, else 0.
// - maskable interrupts blocked while mask gate is 0, allowed when 1.
// - accepting an interrupt clears mask gate.
// - 3-bit priority level; interrupt taken only if priority strictly greater.
// - flag word bits above the field read zero; software writes zero there.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "cpu_regs_cfg.svh"

module cpu_register_set_and_flags
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // alu flag update
  input wire logic alu_update,
  input wire logic [31:0] alu_result,
  input wire logic [1:0] alu_size,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  // program counter load
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  // interrupt and trap events
  input wire logic irq_request,
  input wire logic irq_maskable,
  input wire logic [2:0] irq_priority,
  input wire logic soft_trap,
  input wire logic [5:0] soft_trap_num,
  // status toward the datapath
  output logic irq_accept,
  output logic [15:0] active_stack_ptr,
  output logic bank_select,
  output logic [15:0] frame_base,
  output logic [15:0] static_base,
  output logic [19:0] next_pc,
  output logic [19:0] vector_base
);

  bus_state_e state_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  word16_t bank_ff [0:1][0:6];
  word20_t vbase_ff;
  word20_t pc_ff;
  word16_t usp_ff;
  word16_t isp_ff;
  word16_t sbase_ff;
  flag_t flag_ff;
  logic ack_ff;
  logic [15:0] asp_ff;
  logic bus_wr;
  logic bank;
  logic take_irq;
  logic [31:0] rd_mux;
  logic [15:0] frame_base_ff;
  logic [15:0] nxt_frame_base;

  // merge 16 bits under two byte lanes
  function automatic word16_t merge16(input word16_t old, input logic [15:0] nw,
    input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // merge 20 bits under three byte lanes
  function automatic word20_t merge20(input word20_t old, input logic [19:0] nw,
    input logic [2:0] be);
    merge20 = {be[2] ? nw[19:16] : old[19:16], be[1] ? nw[15:8] : old[15:8],
      be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // offset to banked index
  function automatic logic [2:0] bank_index(input logic [7:0] ofs);
    case (ofs)
      `OFS_GP_WORD_0: bank_index = `IDX_GP_WORD_0;
      `OFS_GP_WORD_1: bank_index = `IDX_GP_WORD_1;
      `OFS_GP_WORD_2: bank_index = `IDX_GP_WORD_2;
      `OFS_GP_WORD_3: bank_index = `IDX_GP_WORD_3;
      `OFS_PTR_REG_0: bank_index = `IDX_PTR_REG_0;
      `OFS_PTR_REG_1: bank_index = `IDX_PTR_REG_1;
      `OFS_FRAME_BASE: bank_index = `IDX_FRAME_BASE;
      default: bank_index = `IDX_NONE;
    endcase
  endfunction

  assign bank = flag_ff[`FLG_GROUP_SEL];
  // write lands on the edge that sees waitrequest low
  assign bus_wr = write && (state_ff == bus_ack);

  assign take_irq = irq_request && (irq_priority > flag_ff[`FLG_PRIO_HI:`FLG_PRIO_LO])
    && (!irq_maskable || flag_ff[`FLG_MASK_GATE]);

  // bus handshake: one wait cycle so read data comes from a flop
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_ff <= bus_idle;
      wait_ff <= 1'b1;
    end
    else
    begin
      unique case (state_ff)
        bus_idle:
        begin
          if (read || write)
          begin
            state_ff <= bus_ack;
            wait_ff <= 1'b0;
          end
        end
        bus_ack:
        begin
          state_ff <= bus_idle;
          wait_ff <= 1'b1;
        end
        default:
        begin
          state_ff <= bus_idle;
          wait_ff <= 1'b1;
        end
      endcase
    end
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (address)
      `OFS_GP_WORD_0, `OFS_GP_WORD_1, `OFS_GP_WORD_2, `OFS_GP_WORD_3,
      `OFS_PTR_REG_0, `OFS_PTR_REG_1, `OFS_FRAME_BASE:
        rd_mux = {16'h0000, bank_ff[bank][bank_index(address)]};
      `OFS_VECTOR_BASE: rd_mux = {12'h000, vbase_ff};
      `OFS_PROG_COUNTER: rd_mux = {12'h000, pc_ff};
      `OFS_USER_SP: rd_mux = {16'h0000, usp_ff};
      `OFS_IRQ_SP: rd_mux = {16'h0000, isp_ff};
      `OFS_STATIC_BASE: rd_mux = {16'h0000, sbase_ff};
      `OFS_FLAG_WORD: rd_mux = {21'h0, flag_ff};
      `OFS_ACTIVE_SP: rd_mux = {16'h0000, asp_ff};
      `OFS_GP_LONG_LOW:
        rd_mux = {bank_ff[bank][`IDX_GP_WORD_2], bank_ff[bank][`IDX_GP_WORD_0]};
      `OFS_GP_LONG_HIGH:
        rd_mux = {bank_ff[bank][`IDX_GP_WORD_3], bank_ff[bank][`IDX_GP_WORD_1]};
      `OFS_PTR_LONG:
        rd_mux = {bank_ff[bank][`IDX_PTR_REG_1], bank_ff[bank][`IDX_PTR_REG_0]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured as waitrequest drops and held until next capture
  always_ff @(posedge clock)
  begin
    if (!rstn)
      rdata_ff <= 32'h0000_0000;
    else if (state_ff == bus_idle && read)
      rdata_ff <= rd_mux;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      for (int b = 0; b < 2; b++)
        for (int i = 0; i < 7; i++)
          bank_ff[b][i] <= `RST_WORD16;
    end
    else if (bus_wr)
    begin
      if (bank_index(address) != `IDX_NONE)
        bank_ff[bank][bank_index(address)] <=
          merge16(bank_ff[bank][bank_index(address)], writedata[15:0], byteenable[1:0]);
      else if (address == `OFS_GP_LONG_LOW)
      begin
        bank_ff[bank][`IDX_GP_WORD_0] <=
          merge16(bank_ff[bank][`IDX_GP_WORD_0], writedata[15:0], byteenable[1:0]);
        bank_ff[bank][`IDX_GP_WORD_2] <=
          merge16(bank_ff[bank][`IDX_GP_WORD_2], writedata[31:16], byteenable[3:2]);
      end
      else if (address == `OFS_GP_LONG_HIGH)
      begin
        bank_ff[bank][`IDX_GP_WORD_1] <=
          merge16(bank_ff[bank][`IDX_GP_WORD_1], writedata[15:0], byteenable[1:0]);
        bank_ff[bank][`IDX_GP_WORD_3] <=
          merge16(bank_ff[bank][`IDX_GP_WORD_3], writedata[31:16], byteenable[3:2]);
      end
      else if (address == `OFS_PTR_LONG)
      begin
        bank_ff[bank][`IDX_PTR_REG_0] <=
          merge16(bank_ff[bank][`IDX_PTR_REG_0], writedata[15:0], byteenable[1:0]);
        bank_ff[bank][`IDX_PTR_REG_1] <=
          merge16(bank_ff[bank][`IDX_PTR_REG_1], writedata[31:16], byteenable[3:2]);
      end
    end
  end

  // frame base of the bank selected after this edge
  always_comb
  begin
    nxt_frame_base = bank_ff[bank][`IDX_FRAME_BASE];
    if (bus_wr && address == `OFS_FLAG_WORD && byteenable[0])
      nxt_frame_base = bank_ff[writedata[`FLG_GROUP_SEL]][`IDX_FRAME_BASE];
    else if (bus_wr && address == `OFS_FRAME_BASE)
      nxt_frame_base = merge16(bank_ff[bank][`IDX_FRAME_BASE], writedata[15:0],
        byteenable[1:0]);
  end

  // lookahead keeps the output a plain flop with no extra cycle of lag
  always_ff @(posedge clock)
  begin
    if (!rstn)
      frame_base_ff <= `RST_WORD16;
    else
      frame_base_ff <= nxt_frame_base;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      vbase_ff <= `RST_WORD20;
    else if (bus_wr && address == `OFS_VECTOR_BASE)
      vbase_ff <= merge20(vbase_ff, writedata[19:0], byteenable[2:0]);
  end

  // program counter; datapath load beats a bus write
  always_ff @(posedge clock)
  begin
    if (!rstn)
      pc_ff <= `RST_WORD20;
    else if (pc_load)
      pc_ff <= pc_value;
    else if (bus_wr && address == `OFS_PROG_COUNTER)
      pc_ff <= merge20(pc_ff, writedata[19:0], byteenable[2:0]);
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sbase_ff <= `RST_WORD16;
      usp_ff <= `RST_WORD16;
      isp_ff <= `RST_WORD16;
    end
    else if (bus_wr)
    begin
      if (address == `OFS_STATIC_BASE)
        sbase_ff <= merge16(sbase_ff, writedata[15:0], byteenable[1:0]);
      if (address == `OFS_USER_SP)
        usp_ff <= merge16(usp_ff, writedata[15:0], byteenable[1:0]);
      if (address == `OFS_IRQ_SP)
        isp_ff <= merge16(isp_ff, writedata[15:0], byteenable[1:0]);
    end
  end

  // flag word: hardware events override a same-cycle software write
  always_ff @(posedge clock)
  begin
    if (!rstn)
      flag_ff <= `RST_FLAG_WORD;
    else
    begin
      if (bus_wr && address == `OFS_FLAG_WORD)
        flag_ff <= {byteenable[1] ? writedata[10:8] : flag_ff[10:8],
          byteenable[0] ? writedata[7:0] : flag_ff[7:0]};
      if (alu_update)
      begin
        flag_ff[`FLG_BORROW_OUT] <= alu_carry;
        flag_ff[`FLG_ARITH_WRAP] <= alu_overflow;
        unique case (alu_size)
          size_byte:
          begin
            flag_ff[`FLG_NULL_RESULT] <= (alu_result[7:0] == 8'h00);
            flag_ff[`FLG_NEGATIVE] <= alu_result[7];
          end
          size_word:
          begin
            flag_ff[`FLG_NULL_RESULT] <= (alu_result[15:0] == 16'h0000);
            flag_ff[`FLG_NEGATIVE] <= alu_result[15];
          end
          default:
          begin
            flag_ff[`FLG_NULL_RESULT] <= (alu_result == 32'h0000_0000);
            flag_ff[`FLG_NEGATIVE] <= alu_result[31];
          end
        endcase
      end
      if (take_irq)
      begin
        flag_ff[`FLG_MASK_GATE] <= 1'b0;
        flag_ff[`FLG_STACK_CHOICE] <= 1'b0;
      end
      if (soft_trap && soft_trap_num < `SOFT_TRAP_SWITCH_LIMIT)
        flag_ff[`FLG_STACK_CHOICE] <= 1'b0;
    end
  end

  // active stack pointer, one cycle behind the flag
  always_ff @(posedge clock)
  begin
    if (!rstn)
      asp_ff <= `RST_WORD16;
    else
      asp_ff <= flag_ff[`FLG_STACK_CHOICE] ? usp_ff : isp_ff;
  end

  // acceptance pulse toward interrupt control
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ack_ff <= 1'b0;
    else
      ack_ff <= take_irq;
  end

  assign readdata = rdata_ff;
  assign waitrequest = wait_ff;
  assign irq_accept = ack_ff;
  assign active_stack_ptr = asp_ff;
  assign bank_select = flag_ff[`FLG_GROUP_SEL];
  assign frame_base = frame_base_ff;
  assign static_base = sbase_ff;
  assign next_pc = pc_ff;
  assign vector_base = vbase_ff;

endmodule

//--- testbench/cpu_regs_props.sv
`timescale 1ns/1ps
`include "cpu_regs_cfg.svh"
module cpu_regs_props
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // events and status
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  input wire logic irq_request,
  input wire logic irq_maskable,
  input wire logic [2:0] irq_priority,
  input wire logic irq_accept,
  input wire logic [15:0] static_base,
  input wire logic [19:0] next_pc,
  input wire logic [19:0] vector_base
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("wait low twice");
  quick_answer_a: assert property ($rose(read) |=> !waitrequest)
    else $error("late answer");
  flag_width_a: assert property (read && !waitrequest && address == `OFS_FLAG_WORD
    |-> readdata[31:11] == 21'h0) else $error("flag bits high");
  vec_hold_a: assert property ($changed(vector_base)
    |-> $past(write) && !$past(waitrequest) && $past(address) == `OFS_VECTOR_BASE)
    else $error("vec moved");
  sb_hold_a: assert property ($changed(static_base)
    |-> $past(write) && !$past(waitrequest) && $past(address) == `OFS_STATIC_BASE)
    else $error("sb moved");
  pc_load_a: assert property (pc_load |=> next_pc == $past(pc_value))
    else $error("pc not loaded");
  accept_cause_a: assert property (irq_accept |-> $past(irq_request))
    else $error("accept unasked");
  gate_close_a: assert property (irq_accept && irq_request && irq_maskable |=> !irq_accept)
    else $error("gate open");
  prio_zero_a: assert property (irq_request && irq_priority == 3'h0 |=> !irq_accept)
    else $error("low prio taken");
  cover property (read && !waitrequest);
  cover property (irq_accept);
  cover property (pc_load);
endmodule
bind cpu_register_set_and_flags cpu_regs_props u_props (.clock, .rstn, .address, .read,
  .write, .readdata, .waitrequest, .pc_load, .pc_value, .irq_request, .irq_maskable,
  .irq_priority, .irq_accept, .static_base, .next_pc, .vector_base);

//--- testbench/datapath_model.sv
`timescale 1ns/1ps
module datapath_model
(
  // clock and acknowledge
  input wire logic clock,
  input wire logic irq_accept,
  // events toward the registers
  output logic alu_update,
  output logic [31:0] alu_result,
  output logic [1:0] alu_size,
  output logic alu_carry,
  output logic alu_overflow,
  output logic pc_load,
  output logic [19:0] pc_value,
  output logic irq_request,
  output logic irq_maskable,
  output logic [2:0] irq_priority,
  output logic soft_trap,
  output logic [5:0] soft_trap_num
);
  int accepts = 0;
  initial
  begin
    {alu_update, alu_result, alu_size, alu_carry, alu_overflow} <= '0;
    {pc_load, pc_value, irq_request, irq_maskable, irq_priority, soft_trap, soft_trap_num} <= '0;
  end
  always @(posedge clock)
    if (irq_accept === 1'b1) accepts++;
  // idle result and carry inverted so stale values never look valid
  task automatic alu(input logic [31:0] r, input logic [1:0] s, input logic c, o);
    alu_result <= r;
    alu_size <= s;
    alu_carry <= c;
    alu_overflow <= o;
    alu_update <= 1'b1;
    @(posedge clock);
    alu_update <= 1'b0;
    alu_result <= ~r;
    alu_carry <= ~c;
    @(posedge clock);
  endtask
  task automatic pc(input logic [19:0] v);
    pc_value <= v;
    pc_load <= 1'b1;
    @(posedge clock);
    pc_load <= 1'b0;
    pc_value <= ~v;
    @(posedge clock);
  endtask
  task automatic irq(input logic m, input logic [2:0] p);
    irq_maskable <= m;
    irq_priority <= p;
    irq_request <= 1'b1;
    repeat (4) @(posedge clock);
    irq_request <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic trap(input logic [5:0] n);
    soft_trap_num <= n;
    soft_trap <= 1'b1;
    @(posedge clock);
    soft_trap <= 1'b0;
    soft_trap_num <= ~n;
    @(posedge clock);
  endtask
endmodule

//--- testbench/test_cpu_register_set_and_flags.sv
`timescale 1ns/1ps
`include "cpu_regs_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_cpu_register_set_and_flags;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rv, alu_result;
  logic waitrequest, alu_update, alu_carry, alu_overflow, pc_load, irq_request;
  logic irq_maskable, soft_trap, irq_accept, bank_select;
  logic [1:0] alu_size;
  logic [19:0] pc_value, next_pc, vector_base;
  logic [2:0] irq_priority;
  logic [5:0] soft_trap_num;
  logic [15:0] active_stack_ptr, frame_base, static_base;
  logic [31:0] ex [12];
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clock = ~clock;
  cpu_register_set_and_flags DUT (.clock, .rstn, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .alu_update, .alu_result, .alu_size, .alu_carry,
    .alu_overflow, .pc_load, .pc_value, .irq_request, .irq_maskable, .irq_priority,
    .soft_trap, .soft_trap_num, .irq_accept, .active_stack_ptr, .bank_select, .frame_base,
    .static_base, .next_pc, .vector_base);
  datapath_model dp (.clock, .irq_accept, .alu_update, .alu_result, .alu_size, .alu_carry,
    .alu_overflow, .pc_load, .pc_value, .irq_request, .irq_maskable, .irq_priority,
    .soft_trap, .soft_trap_num);
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rv = readdata;
    read <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [3:0] cpu_flag_word(input logic [31:0] r, input logic [1:0] s, input logic c, o);
    logic [31:0] m;
    m = (s == 2'h0) ? 32'hff : (s == 2'h1) ? 32'hffff : 32'hffffffff;
    return {o, (r & (m ^ (m >> 1))) != 32'h0, (r & m) == 32'h0, c};
  endfunction
  task automatic results();
    $display("mismatches %0d checks %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard; the whole run needs a few hundred cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    logic [31:0] d;
    d = $urandom(32'h6357dbba);
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 12; i++)
    begin
      rd(8'(i * 4));
      `CHK(rv, 32'h0);
      d = $urandom;
      wr(8'(i * 4), d, 4'hf);
      ex[i] = d & ((i == 7 || i == 8) ? 32'hfffff : 32'hffff);
    end
    for (int i = 0; i < 12; i++)
    begin
      rd(8'(i * 4));
      `CHK(rv, ex[i]);
    end
    `CHK({vector_base, static_base}, {ex[7][19:0], ex[11][15:0]});
    rd(8'h44);
    `CHK(rv, 32'h0);
    rd(`OFS_GP_LONG_LOW);
    `CHK(rv, {ex[2][15:0], ex[0][15:0]});
    rd(`OFS_GP_LONG_HIGH);
    `CHK(rv, {ex[3][15:0], ex[1][15:0]});
    rd(`OFS_PTR_LONG);
    `CHK(rv, {ex[5][15:0], ex[4][15:0]});
    wr(`OFS_GP_LONG_HIGH, 32'h1234_5678, 4'hf);
    rd(`OFS_GP_WORD_3);
    `CHK(rv, 32'h1234);
    wr(`OFS_PTR_LONG, 32'h9abc_def0, 4'h3);
    rd(`OFS_PTR_LONG);
    `CHK(rv, {ex[5][15:0], 16'hdef0});
    wr(`OFS_FLAG_WORD, 32'h10, 4'hf);
    `CHK(bank_select, 1'b1);
    wr(`OFS_GP_WORD_0, 32'h5a5a, 4'hf);
    wr(`OFS_GP_WORD_0, 32'ha700, 4'h2);
    wr(`OFS_FRAME_BASE, 32'h1234, 4'hf);
    `CHK(frame_base, 16'h1234);
    rd(`OFS_GP_WORD_0);
    `CHK(rv, 32'ha75a);
    wr(`OFS_GP_WORD_0, 32'h3c, 4'h1);
    rd(`OFS_GP_WORD_0);
    `CHK(rv, 32'ha73c);
    wr(`OFS_FLAG_WORD, 32'h0, 4'hf);
    rd(`OFS_GP_WORD_0);
    `CHK(rv, ex[0]);
    `CHK(frame_base, ex[6][15:0]);
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'h100 : (i == 1) ? 32'h8000 : $urandom;
      dp.alu(d, 2'(i % 4), i[0], i[1]);
      rd(`OFS_FLAG_WORD);
      `CHK({rv[5], rv[3], rv[2], rv[0]}, cpu_flag_word(d, 2'(i % 4), i[0], i[1]));
    end
    // gate open, user stack, level 3
    wr(`OFS_FLAG_WORD, 32'h3c0, 4'hf);
    rd(`OFS_ACTIVE_SP);
    `CHK(rv[15:0], ex[9][15:0]);
    dp.irq(1'b1, 3'h3);
    `CHK(dp.accepts, 0);
    dp.irq(1'b1, 3'h4);
    `CHK(dp.accepts, 1);
    rd(`OFS_FLAG_WORD);
    `CHK(rv[10:6], 5'h0c);
    `CHK(active_stack_ptr, ex[10][15:0]);
    dp.irq(1'b1, 3'h7);
    `CHK(dp.accepts, 1);
    wr(`OFS_FLAG_WORD, 32'h80, 4'hf);
    dp.trap(6'h20);
    rd(`OFS_FLAG_WORD);
    `CHK(rv[7], 1'b1);
    dp.trap(6'h1f);
    rd(`OFS_FLAG_WORD);
    `CHK(rv[7], 1'b0);
    dp.irq(1'b0, 3'h0);
    `CHK(dp.accepts, 1);
    d = $urandom;
    dp.pc(d[19:0]);
    `CHK(next_pc, d[19:0]);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(`OFS_GP_WORD_0);
    `CHK(rv, 32'h0);
    results();
  end
endmodule
